// ---- hw/timer_cfg.svh ----
// Behaviour
// R01 - Timer 1 overflow sets its flag; service entry clears it; software may write it.
// R02 - Timer 0 overflow sets its flag; service entry clears it; software may write it.
// R03 - A timer counts only while its run bit is 1; stopping keeps the count.
// R04 - Edge mode: falling pin edge sets the flag until software or service entry clears it.
// R05 - Level mode: flag follows the inverted pin; software writes are ignored.
// R06 - Type bit 0 selects low level, 1 selects falling edge triggering.
// R07 - Gate 0 ignores the interrupt pin; gate 1 also needs the pin high.
// R08 - Counter/timer bit 0 counts clock ticks, 1 counts falling count-pin edges.
// R09 - Mode 00 runs a 13-bit timer/counter.
// R10 - Mode 01 runs a 16-bit timer/counter from high and low bytes.
// R11 - Mode 10 runs an 8-bit low byte reloaded from the high byte.
// R12 - Timer 1 in mode 11 is halted.
// R13 - Timer 0 in mode 11 splits into low counter and separate high timer.
// R14 - Each count is two readable and writable bytes, low and high.
// R15 - Timer tick is system clock divided by 12 unless fast clock chosen.
// R16 - 13-bit mode uses low five bits of low byte; wrap from all ones flags.
// R17 - Reload mode copies high byte into low byte on overflow and flags it.
// R18 - Per-source service entry pulses clear overflow and edge-mode external flags.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define ADDR_TCTL 8'h88
`define ADDR_TMODE 8'h89
`define ADDR_T0_LOW 8'h8A
`define ADDR_T1_LOW 8'h8B
`define ADDR_T0_HIGH 8'h8C
`define ADDR_T1_HIGH 8'h8D
`define ADDR_CLKMODE 8'h8E
`define ADDR_IRQ_STATUS 8'h95
`define ADDR_IRQ_CLEAR 8'h96
`define ADDR_IRQ_ENABLE 8'h97
`define TMR_PRESCALE 12
`define BIT_T1_OVF 7
`define BIT_T1_RUN 6
`define BIT_T0_OVF 5
`define BIT_T0_RUN 4
`define BIT_X1_FLAG 3
`define BIT_X1_TYPE 2
`define BIT_X0_FLAG 1
`define BIT_X0_TYPE 0
`define T1_SHIFT 4
`define CLKMODE_MASK 8'h18
`define PIN_IDLE 4'hF
`define BIT_FAST1 4
`define BIT_FAST0 3
`define BIT_GATE 3
`define BIT_CT 2
`define MODE_LO 0
`define MODE_HI 1
`define BYTE_RESET 8'h00
`define BYTE_ONES 8'hFF
`define EV_T0 0
`define EV_T1 1
`define EV_X0 2
`define EV_X1 3
`endif

// ---- hw/timer_pkg.sv ----
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } timer_mode_e;
endpackage

// ---- hw/dual_timer_ext_irq_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "timer_cfg.svh"
module dual_timer_ext_irq_ctrl #(
  parameter int PRESCALE = `TMR_PRESCALE
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rdata_o,
  input wire logic ext_irq0_pin_n_i,
  input wire logic ext_irq1_pin_n_i,
  input wire logic count0_input_pin_i,
  input wire logic count1_input_pin_i,
  input wire logic timer0_irq_ack_i,
  input wire logic timer1_irq_ack_i,
  input wire logic ext_irq0_ack_i,
  input wire logic ext_irq1_ack_i,
  output logic timer0_overflow_flag_o,
  output logic timer1_overflow_flag_o,
  output logic ext_irq0_flag_o,
  output logic ext_irq1_flag_o,
  output logic irq_o
);

  // One timer step: returns {overflow, high, low}
  function automatic logic [16:0] step(input timer_pkg::timer_mode_e m,
                                       input logic [7:0] th,
                                       input logic [7:0] tl);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [7:0] c8;
    c13 = {th, tl[4:0]} + 13'h0001;
    c16 = {th, tl} + 16'h0001;
    c8 = tl + 8'h01;
    unique case (m)
      timer_pkg::MODE_13BIT:
        step = {&{th, tl[4:0]}, c13[12:5], tl[7:5], c13[4:0]}; // [R09] [R16]
      timer_pkg::MODE_16BIT:
        step = {&{th, tl}, c16}; // [R10]
      timer_pkg::MODE_RELOAD8:
        step = (tl == `BYTE_ONES) ? {1'b1, th, th} : {1'b0, th, c8}; // [R11] [R17]
      timer_pkg::MODE_SPLIT:
        step = {tl == `BYTE_ONES, th, c8}; // [R13]
    endcase
  endfunction

  localparam logic [3:0] PRE_LAST = 4'(PRESCALE - 1);

  // True when a strobe hits the given register address
  function automatic logic addr_hit(input logic strobe,
                                    input logic [7:0] a,
                                    input logic [7:0] target);
    addr_hit = strobe && (a == target);
  endfunction

  // Control, mode and clock-mode registers
  logic [7:0] ctl;
  logic [7:0] tmode;
  logic [7:0] clkmode;
  // Count bytes of both timers
  logic [7:0] cnt0_lo;
  logic [7:0] cnt0_hi;
  logic [7:0] cnt1_lo;
  logic [7:0] cnt1_hi;
  // Sticky status and enable, ordered {x1, x0, t1, t0}
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic [3:0] clear_mask;
  logic [3:0] hw_events;
  // Divide-by-12 prescaler
  logic [3:0] pre_cnt;
  logic tick12;
  // Pin synchronisers, ordered {count1, count0, ext_irq1_pin_n, ext_irq0_pin_n}
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_prev;
  logic [3:0] pin_fall;
  // Next count values
  logic [7:0] next_cnt0_lo;
  logic [7:0] next_cnt0_hi;
  logic [7:0] next_cnt1_lo;
  logic [7:0] next_cnt1_hi;
  // Overflow events
  logic ovf0;
  logic ovf1;
  logic ovf_hi0;
  // Increment enables and their parts
  logic en0;
  logic en1;
  logic en_hi0;
  logic tclk0;
  logic tclk1;
  logic src0;
  logic src1;
  logic gate_ok0;
  logic gate_ok1;
  // Flag set events
  logic set_ovf0;
  logic set_ovf1;
  logic set_x0;
  logic set_x1;
  // Register write decodes
  logic wr_ctl;
  logic wr_tmode;
  logic wr_clkmode;
  logic wr_cnt0_lo;
  logic wr_cnt0_hi;
  logic wr_cnt1_lo;
  logic wr_cnt1_hi;
  logic wr_irq_clear;
  logic wr_irq_enable;
  // Decoded mode of each timer
  timer_pkg::timer_mode_e mode0;
  timer_pkg::timer_mode_e mode1;

  // Write decodes, one per writable register
  assign wr_ctl = addr_hit(wr_en_i, addr_i, `ADDR_TCTL);
  assign wr_tmode = addr_hit(wr_en_i, addr_i, `ADDR_TMODE);
  assign wr_clkmode = addr_hit(wr_en_i, addr_i, `ADDR_CLKMODE);
  assign wr_cnt0_lo = addr_hit(wr_en_i, addr_i, `ADDR_T0_LOW);
  assign wr_cnt0_hi = addr_hit(wr_en_i, addr_i, `ADDR_T0_HIGH);
  assign wr_cnt1_lo = addr_hit(wr_en_i, addr_i, `ADDR_T1_LOW);
  assign wr_cnt1_hi = addr_hit(wr_en_i, addr_i, `ADDR_T1_HIGH);
  assign wr_irq_clear = addr_hit(wr_en_i, addr_i, `ADDR_IRQ_CLEAR);
  assign wr_irq_enable = addr_hit(wr_en_i, addr_i, `ADDR_IRQ_ENABLE);

  // Mode fields; every two-bit code is a legal mode
  assign mode0 = timer_pkg::timer_mode_e'(tmode[`MODE_HI:`MODE_LO]);
  assign mode1 = timer_pkg::timer_mode_e'(
                   tmode[`MODE_HI+`T1_SHIFT:`MODE_LO+`T1_SHIFT]);

  // Divide-by-12 tick; free running, so its phase ignores the run bits
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pre_cnt <= 4'h0;
      tick12 <= 1'b0;
    end else if (pre_cnt == PRE_LAST) begin
      pre_cnt <= 4'h0;
      tick12 <= 1'b1; // [R15]
    end else begin
      pre_cnt <= pre_cnt + 4'h1;
      tick12 <= 1'b0;
    end
  end

  // Two-stage sync of the pins plus edge history; idle high after reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_s1 <= `PIN_IDLE;
      pin_s2 <= `PIN_IDLE;
      pin_prev <= `PIN_IDLE;
    end else begin
      pin_s1 <= {count1_input_pin_i, count0_input_pin_i,
                 ext_irq1_pin_n_i, ext_irq0_pin_n_i};
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  // Falling edges seen on the synchronised pins
  assign pin_fall = pin_prev & ~pin_s2;

  // Timer 0 increment enable
  always_comb begin
    tclk0 = clkmode[`BIT_FAST0] | tick12; // [R15]
    src0 = tmode[`BIT_CT] ? pin_fall[2] : tclk0; // [R08]
    gate_ok0 = ~tmode[`BIT_GATE] | pin_s2[0]; // [R07]
    en0 = ctl[`BIT_T0_RUN] & gate_ok0 & src0; // [R03]
  end

  // Timer 1 increment enable; mode 11 holds timer 1 still
  always_comb begin
    tclk1 = clkmode[`BIT_FAST1] | tick12; // [R15]
    src1 = tmode[`BIT_CT+`T1_SHIFT] ? pin_fall[3] : tclk1; // [R08]
    gate_ok1 = ~tmode[`BIT_GATE+`T1_SHIFT] | pin_s2[1]; // [R07]
    en1 = ctl[`BIT_T1_RUN] & gate_ok1 & src1
          & (mode1 != timer_pkg::MODE_SPLIT); // [R03] [R12]
  end

  // Split high byte: timer 0 clock, timer 1 run bit
  always_comb begin
    en_hi0 = (mode0 == timer_pkg::MODE_SPLIT) & ctl[`BIT_T1_RUN]
             & tclk0; // [R13]
  end

  // Timer 0 next count; the split high byte steps on its own
  always_comb begin
    next_cnt0_lo = cnt0_lo;
    next_cnt0_hi = cnt0_hi;
    ovf0 = 1'b0;
    ovf_hi0 = 1'b0;
    if (en0) begin
      {ovf0, next_cnt0_hi, next_cnt0_lo} = step(mode0, cnt0_hi, cnt0_lo);
    end
    if (en_hi0) begin
      next_cnt0_hi = cnt0_hi + 8'h01; // [R13]
      ovf_hi0 = (cnt0_hi == `BYTE_ONES);
    end
  end

  // Timer 1 next count
  always_comb begin
    next_cnt1_lo = cnt1_lo;
    next_cnt1_hi = cnt1_hi;
    ovf1 = 1'b0;
    if (en1) begin
      {ovf1, next_cnt1_hi, next_cnt1_lo} = step(mode1, cnt1_hi, cnt1_lo);
    end
  end

  // Flag set events; a split timer 0 takes over the timer 1 flag
  always_comb begin
    set_ovf0 = ovf0; // [R02]
    set_ovf1 = ovf_hi0
               | (ovf1 & (mode0 != timer_pkg::MODE_SPLIT)); // [R01] [R13]
    set_x0 = ctl[`BIT_X0_TYPE] & pin_fall[0]; // [R04] [R06]
    set_x1 = ctl[`BIT_X1_TYPE] & pin_fall[1]; // [R04] [R06]
    hw_events = {set_x1, set_x0, set_ovf1, set_ovf0};
  end

  // Timer 0 count bytes; a software write takes its byte over the step
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt0_lo <= `BYTE_RESET;
      cnt0_hi <= `BYTE_RESET;
    end else begin
      cnt0_lo <= wr_cnt0_lo ? wdata_i : next_cnt0_lo; // [R14]
      cnt0_hi <= wr_cnt0_hi ? wdata_i : next_cnt0_hi; // [R14]
    end
  end

  // Timer 1 count bytes, same write priority
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt1_lo <= `BYTE_RESET;
      cnt1_hi <= `BYTE_RESET;
    end else begin
      cnt1_lo <= wr_cnt1_lo ? wdata_i : next_cnt1_lo; // [R14]
      cnt1_hi <= wr_cnt1_hi ? wdata_i : next_cnt1_hi; // [R14]
    end
  end

  // Run and type bits; the flag bits here are shadowed by the flag flops
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctl <= `BYTE_RESET;
    end else if (wr_ctl) begin
      ctl <= wdata_i; // [R03] [R06]
    end
  end

  // Mode register of both timers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tmode <= `BYTE_RESET;
    end else if (wr_tmode) begin
      tmode <= wdata_i; // [R09] [R10] [R11]
    end
  end

  // Clock-mode register keeps only the two fast-clock bits
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      clkmode <= `BYTE_RESET;
    end else if (wr_clkmode) begin
      clkmode <= wdata_i & `CLKMODE_MASK; // [R15]
    end
  end

  // Timer 0 overflow flag: hardware set beats service entry and software
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      timer0_overflow_flag_o <= 1'b0;
    end else if (set_ovf0) begin
      timer0_overflow_flag_o <= 1'b1; // [R02]
    end else if (timer0_irq_ack_i) begin
      timer0_overflow_flag_o <= 1'b0; // [R02] [R18]
    end else if (wr_ctl) begin
      timer0_overflow_flag_o <= wdata_i[`BIT_T0_OVF]; // [R02]
    end
  end

  // Timer 1 overflow flag, same priority
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      timer1_overflow_flag_o <= 1'b0;
    end else if (set_ovf1) begin
      timer1_overflow_flag_o <= 1'b1; // [R01]
    end else if (timer1_irq_ack_i) begin
      timer1_overflow_flag_o <= 1'b0; // [R01] [R18]
    end else if (wr_ctl) begin
      timer1_overflow_flag_o <= wdata_i[`BIT_T1_OVF]; // [R01]
    end
  end

  // External flag 0: level mode tracks the pin, edge mode is sticky
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ext_irq0_flag_o <= 1'b0;
    end else if (!ctl[`BIT_X0_TYPE]) begin
      ext_irq0_flag_o <= ~pin_s2[0]; // [R05] [R06]
    end else if (set_x0) begin
      ext_irq0_flag_o <= 1'b1; // [R04]
    end else if (ext_irq0_ack_i) begin
      ext_irq0_flag_o <= 1'b0; // [R04] [R18]
    end else if (wr_ctl) begin
      ext_irq0_flag_o <= wdata_i[`BIT_X0_FLAG]; // [R04]
    end
  end

  // External flag 1, same scheme
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ext_irq1_flag_o <= 1'b0;
    end else if (!ctl[`BIT_X1_TYPE]) begin
      ext_irq1_flag_o <= ~pin_s2[1]; // [R05] [R06]
    end else if (set_x1) begin
      ext_irq1_flag_o <= 1'b1; // [R04]
    end else if (ext_irq1_ack_i) begin
      ext_irq1_flag_o <= 1'b0; // [R04] [R18]
    end else if (wr_ctl) begin
      ext_irq1_flag_o <= wdata_i[`BIT_X1_FLAG]; // [R04]
    end
  end

  // Write-one-to-clear mask for the status register
  assign clear_mask = wr_irq_clear ? wdata_i[3:0] : 4'h0;

  // Sticky event status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_status <= 4'h0;
    end else begin
      irq_status <= (irq_status & ~clear_mask) | hw_events;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_enable <= 4'h0;
    end else if (wr_irq_enable) begin
      irq_enable <= wdata_i[3:0];
    end
  end

  // Level interrupt while an enabled status bit is set
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o <= `BYTE_RESET;
    end else if (rd_en_i) begin
      case (addr_i)
        `ADDR_TCTL: rdata_o <= {timer1_overflow_flag_o, ctl[`BIT_T1_RUN],
                                timer0_overflow_flag_o, ctl[`BIT_T0_RUN],
                                ext_irq1_flag_o, ctl[`BIT_X1_TYPE],
                                ext_irq0_flag_o, ctl[`BIT_X0_TYPE]};
        `ADDR_TMODE: rdata_o <= tmode;
        `ADDR_T0_LOW: rdata_o <= cnt0_lo; // [R14]
        `ADDR_T1_LOW: rdata_o <= cnt1_lo; // [R14]
        `ADDR_T0_HIGH: rdata_o <= cnt0_hi; // [R14]
        `ADDR_T1_HIGH: rdata_o <= cnt1_hi; // [R14]
        `ADDR_CLKMODE: rdata_o <= clkmode;
        `ADDR_IRQ_STATUS: rdata_o <= {4'h0, irq_status};
        `ADDR_IRQ_ENABLE: rdata_o <= {4'h0, irq_enable};
        default: rdata_o <= `BYTE_RESET;
      endcase
    end else begin
      rdata_o <= `BYTE_RESET;
    end
  end

endmodule
`default_nettype wire

// ---- testbench/timer_port_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer_port_monitor (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rdata_o,
  input wire logic ext_irq0_pin_n_i,
  input wire logic ext_irq1_pin_n_i,
  input wire logic timer0_irq_ack_i,
  input wire logic timer1_irq_ack_i,
  input wire logic ext_irq1_ack_i,
  input wire logic timer0_overflow_flag_o,
  input wire logic timer1_overflow_flag_o,
  input wire logic ext_irq0_flag_o,
  input wire logic ext_irq1_flag_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // Bus answer slot
  property p_rd_slot;
    rdata_o != 8'h00 |-> $past(rd_en_i);
  endproperty
  a_rd_slot: assert property (p_rd_slot)
    else $error("read data outside its slot");
  property p_rd_hole;
    rd_en_i && addr_i == 8'h00 |=> rdata_o == 8'h00;
  endproperty
  a_rd_hole: assert property (p_rd_hole)
    else $error("unmapped read not zero");
  // Flag set and clear causes
  property p_t0_clr;
    $fell(timer0_overflow_flag_o) |-> $past(timer0_irq_ack_i) || $past(wr_en_i);
  endproperty
  a_t0_clr: assert property (p_t0_clr)
    else $error("timer0 flag dropped without cause");
  property p_t1_clr;
    $fell(timer1_overflow_flag_o) |-> $past(timer1_irq_ack_i) || $past(wr_en_i);
  endproperty
  a_t1_clr: assert property (p_t1_clr)
    else $error("timer1 flag dropped without cause");
  property p_x0_set;
    $rose(ext_irq0_flag_o) |-> $past(wr_en_i) || !$past(ext_irq0_pin_n_i, 3)
      || !$past(ext_irq0_pin_n_i, 4) || !$past(ext_irq0_pin_n_i, 5);
  endproperty
  a_x0_set: assert property (p_x0_set)
    else $error("ext0 flag set without low pin");
  property p_x1_clr;
    $fell(ext_irq1_flag_o) |-> $past(wr_en_i) || $past(ext_irq1_ack_i)
      || $past(ext_irq1_pin_n_i, 3) || $past(ext_irq1_pin_n_i, 4);
  endproperty
  a_x1_clr: assert property (p_x1_clr)
    else $error("ext1 flag dropped without cause");
  // Interrupt line follows status and enable
  property p_irq_up;
    $rose(irq_o) |-> $past(wr_en_i, 2) || $past(timer0_overflow_flag_o)
      || $past(timer1_overflow_flag_o) || $past(ext_irq0_flag_o)
      || $past(ext_irq1_flag_o);
  endproperty
  a_irq_up: assert property (p_irq_up)
    else $error("interrupt raised without event");
  property p_irq_dn;
    $fell(irq_o) |-> $past(wr_en_i, 2);
  endproperty
  a_irq_dn: assert property (p_irq_dn)
    else $error("interrupt dropped without write");
endmodule
bind dual_timer_ext_irq_ctrl timer_port_monitor u_mon (.clk_sys_i, .srst_i,
  .addr_i, .wr_en_i, .rd_en_i, .rdata_o, .ext_irq0_pin_n_i, .ext_irq1_pin_n_i,
  .timer0_irq_ack_i, .timer1_irq_ack_i, .ext_irq1_ack_i,
  .timer0_overflow_flag_o, .timer1_overflow_flag_o, .ext_irq0_flag_o,
  .ext_irq1_flag_o, .irq_o);
`default_nettype wire

// ---- testbench/isr_entry_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module isr_entry_model #(
  parameter int DELAY = 2
) (
  input wire logic clk_i,
  input wire logic serve_i,
  input wire logic [3:0] flag_i,
  output logic [3:0] ack_o
);
  int wait_cnt = 0;
  // One service entry at a time, lowest source first
  always_ff @(posedge clk_i) begin
    ack_o <= 4'h0;
    if (!serve_i || flag_i == 4'h0 || ack_o != 4'h0) begin
      wait_cnt <= 0;
    end else if (wait_cnt < DELAY) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      ack_o <= flag_i & (~flag_i + 4'h1);
      wait_cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dual_timer_ext_irq_ctrl_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module dual_timer_ext_irq_ctrl_test;
  logic clk_sys_i = 0;
  logic srst_i = 1;
  logic wr_en_i = 0;
  logic rd_en_i = 0;
  logic serve = 0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] v;
  logic [7:0] s;
  logic [1:0] xp_n = 2'h3;
  logic [1:0] cp = 2'h3;
  wire logic [7:0] rdata_o;
  wire logic [3:0] ack;
  wire logic [3:0] flg;
  wire logic irq_o;
  int failures = 0;
  int n_checks = 0;
  int tn = 0;
  dual_timer_ext_irq_ctrl dut (.clk_sys_i, .srst_i, .addr_i, .wdata_i,
    .wr_en_i, .rd_en_i, .rdata_o, .ext_irq0_pin_n_i(xp_n[0]),
    .ext_irq1_pin_n_i(xp_n[1]), .count0_input_pin_i(cp[0]),
    .count1_input_pin_i(cp[1]), .timer0_irq_ack_i(ack[0]),
    .timer1_irq_ack_i(ack[1]), .ext_irq0_ack_i(ack[2]),
    .ext_irq1_ack_i(ack[3]), .timer0_overflow_flag_o(flg[0]),
    .timer1_overflow_flag_o(flg[1]), .ext_irq0_flag_o(flg[2]),
    .ext_irq1_flag_o(flg[3]), .irq_o);
  isr_entry_model #(.DELAY(3)) core (.clk_i(clk_sys_i), .serve_i(serve),
    .flag_i(flg), .ack_o(ack));
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_en_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Bounded wait for a flag to reach a level
  task automatic waitf(input int i, input logic lvl);
    for (int k = 0; k < 40 && flg[i] !== lvl; k++) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  task automatic done();
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    // Reset values, byte access, unmapped read
    for (int a = 8'h88; a < 8'h8E; a++) begin
      rd(8'(a));
      chk(v, 8'h00);
    end
    rd(8'h00);
    chk(v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h8A + i), 8'(8'h50 + i));
      rd(8'(8'h8A + i));
      chk(v, 8'(8'h50 + i));
    end
    done();
    // 16-bit overflow, stop, service entry, status clear
    wr(8'h8E, 8'h18);
    wr(8'h89, 8'h01);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hFF);
    wr(8'h97, 8'h0F);
    wr(8'h88, 8'h10);
    waitf(0, 1'b1);
    chk(flg[0], 1'b1);
    @(posedge clk_sys_i);
    #1 chk(irq_o, 1'b1);
    wr(8'h88, 8'h20);
    rd(8'h8C);
    chk(v, 8'h00);
    rd(8'h8A);
    s = v;
    rd(8'h8A);
    chk(v, s);
    serve <= 1'b1;
    waitf(0, 1'b0);
    chk(flg[0], 1'b0);
    serve <= 1'b0;
    rd(8'h95);
    chk(v, 8'h01);
    wr(8'h96, 8'h0F);
    @(posedge clk_sys_i);
    #1 chk(irq_o, 1'b0);
    done();
    // Auto-reload, then halted mode
    wr(8'h8D, 8'hF0);
    wr(8'h8B, 8'hFE);
    wr(8'h89, 8'h20);
    wr(8'h88, 8'h40);
    waitf(1, 1'b1);
    chk(flg[1], 1'b1);
    wr(8'h88, 8'h80);
    rd(8'h8D);
    chk(v, 8'hF0);
    rd(8'h8B);
    chk({4'h0, v[7:4]}, 8'h0F);
    wr(8'h89, 8'h30);
    rd(8'h8B);
    s = v;
    wr(8'h88, 8'h40);
    repeat (20) @(posedge clk_sys_i);
    rd(8'h8B);
    chk(v, s);
    done();
    // 13-bit wrap from 1FFE
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'h1E);
    wr(8'h88, 8'h10);
    waitf(0, 1'b1);
    chk(flg[0], 1'b1);
    wr(8'h88, 8'h20);
    rd(8'h8C);
    chk(v, 8'h00);
    done();
    // Gate held closed by low pin, then opened
    wr(8'h88, 8'h00);
    wr(8'h8A, 8'h00);
    wr(8'h89, 8'h09);
    xp_n[0] <= 1'b0;
    wr(8'h88, 8'h10);
    repeat (10) @(posedge clk_sys_i);
    rd(8'h8A);
    chk(v, 8'h00);
    xp_n[0] <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    wr(8'h88, 8'h00);
    rd(8'h8A);
    chk(8'(v != 8'h00), 8'h01);
    done();
    // Counter on count-pin falls, then prescaled timer
    wr(8'h8E, 8'h00);
    wr(8'h89, 8'h05);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    repeat (3) begin
      cp[0] <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      cp[0] <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
    end
    wr(8'h88, 8'h00);
    rd(8'h8A);
    chk(v, 8'h03);
    wr(8'h89, 8'h01);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    repeat (120) @(posedge clk_sys_i);
    wr(8'h88, 8'h00);
    rd(8'h8A);
    chk(8'(v inside {[8'h09:8'h0B]}), 8'h01);
    done();
    // Falling-edge flags held, then cleared by service entry
    for (int i = 0; i < 2; i++) begin
      wr(8'h88, 8'h05);
      xp_n[i] <= 1'b0;
      waitf(i + 2, 1'b1);
      xp_n[i] <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      chk(flg[i+2], 1'b1);
      serve <= 1'b1;
      waitf(i + 2, 1'b0);
      chk(flg[i+2], 1'b0);
      serve <= 1'b0;
    end
    // Level mode follows pin, ignores writes
    wr(8'h88, 8'h00);
    xp_n[0] <= 1'b0;
    waitf(2, 1'b1);
    chk(flg[2], 1'b1);
    xp_n[0] <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    wr(8'h88, 8'h02);
    chk(flg[2], 1'b0);
    done();
    // Split timer 0: low and high byte overflow on their own
    wr(8'h8E, 8'h18);
    wr(8'h89, 8'h43);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFE);
    wr(8'h88, 8'h50);
    waitf(0, 1'b1);
    waitf(1, 1'b1);
    chk(flg[0], 1'b1);
    chk(flg[1], 1'b1);
    wr(8'h88, 8'h00);
    rd(8'h8C);
    chk(8'(v < 8'h10), 8'h01);
    // Timer 1 counting falls of its count pin
    wr(8'h89, 8'h50);
    wr(8'h8B, 8'h00);
    wr(8'h88, 8'h40);
    repeat (2) begin
      cp[1] <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      cp[1] <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
    end
    wr(8'h88, 8'h00);
    rd(8'h8B);
    chk(v, 8'h02);
    done();
    final_report();
  end
endmodule
`default_nettype wire
